// file: verilog/step_down_ctrl_pkg.sv
// Register map, field positions and timing constants of the step-down control block
package step_down_ctrl_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_STATUS       = 8'h01;
  localparam logic [7:0] ADDR_ENABLE       = 8'h02;
  localparam logic [7:0] ADDR_MODE         = 8'h03;
  localparam logic [7:0] ADDR_DISCHARGE    = 8'h04;
  localparam logic [7:0] ADDR_B_LOW        = 8'h05;
  localparam logic [7:0] ADDR_B_HIGH       = 8'h06;
  localparam logic [7:0] ADDR_SLEW         = 8'h07;

  // ****************************************************************
  // Reset values and writable masks
  // ****************************************************************
  localparam logic [7:0] RST_ENABLE        = 8'h00;
  localparam logic [7:0] RST_MODE          = 8'h00;
  localparam logic [7:0] RST_DISCHARGE     = 8'h0F;
  localparam logic [7:0] RST_B_LOW         = 8'h10;
  localparam logic [7:0] RST_B_HIGH        = 8'h08;
  localparam logic [7:0] RST_SLEW          = 8'h06;
  localparam logic [7:0] MASK_ENABLE       = 8'h40;
  localparam logic [7:0] MASK_MODE         = 8'h0F;
  localparam logic [7:0] MASK_DISCHARGE    = 8'h3F;
  localparam logic [7:0] MASK_CODE         = 8'h3F;
  localparam logic [7:0] MASK_SLEW         = 8'h07;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int POS_POWER_DOWN    = 6;
  localparam int POS_RIPPLE_A      = 3;
  localparam int POS_RIPPLE_B      = 2;
  localparam int POS_FPWM_A        = 1;
  localparam int POS_FPWM_B        = 0;
  localparam int POS_RAMP_FLAG     = 7;
  localparam int POS_RAMP_MIRROR   = 6;

  // ****************************************************************
  // Voltage code regions and slew timing
  // ****************************************************************
  localparam logic [5:0] CODE_FINE_TOP     = 6'h1F;
  localparam logic [5:0] CODE_COARSE_TOP   = 6'h3B;
  localparam int STEP_FINE_UV      = 25000;
  localparam int STEP_COARSE_UV    = 50000;
  localparam int STEP_TOP_UV       = 100000;
  localparam logic [2:0] SLEW_IMMEDIATE    = 3'h7;
  // Ramp rate per slew code; code 7 is immediate, its entry only fills the table
  localparam int SLEW_RATE_UV_PER_US [8] = '{110, 220, 450, 900, 1800, 3600, 7200, 7200};
  localparam int CLK_PERIOD_NS     = 100;
  localparam int NS_PER_US         = 1000;
  localparam logic [3:0] BITS_PER_BYTE     = 4'h8;

  typedef enum logic [3:0] {
    BUS_IDLE, BUS_ADDR, BUS_ACK_ADDR, BUS_REG, BUS_ACK_REG,
    BUS_WDATA, BUS_ACK_WDATA, BUS_RDATA, BUS_RACK
  } bus_state_e;

  typedef enum logic {
    RAMP_IDLE, RAMP_MOVING
  } ramp_state_e;

endpackage

// file: verilog/step_down_mode_and_voltage_ctrl.sv
// Serial-bus register file, mode bits and converter B voltage ramp
`timescale 1ns/1ns
module step_down_mode_and_voltage_ctrl #(
  parameter logic [6:0] SLAVE_ADDR    = 7'h48,
  parameter int         CLK_PERIOD_NS = step_down_ctrl_pkg::CLK_PERIOD_NS
) (
  // Clock and undervoltage lockout reset
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  // Serial bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // Target select pin
  input  wire logic       target_select_pin_i,
  // Converter controls
  output logic            power_down_output_o,
  output logic            power_down_output_oe_o,
  output logic            ripple_opt_a_o,
  output logic            ripple_opt_b_o,
  output logic            forced_pwm_a_o,
  output logic            forced_pwm_b_o,
  output logic [5:0]      discharge_en_o,
  output logic [5:0]      converter_b_code_o,
  output logic            converter_b_ramp_o
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] scl_sync_r, sda_sync_r, sel_sync_r;
  logic       scl_d_r, sda_d_r;

  always_ff @(posedge clock_i) begin
    scl_sync_r <= {scl_sync_r[0], scl_i};
    sda_sync_r <= {sda_sync_r[0], sda_i};
    sel_sync_r <= {sel_sync_r[0], target_select_pin_i};
    scl_d_r    <= scl_sync_r[1];
    sda_d_r    <= sda_sync_r[1];
  end

  logic scl, sda, scl_rise, scl_fall, bus_start, bus_stop;
  assign scl       = scl_sync_r[1];
  assign sda       = sda_sync_r[1];
  assign scl_rise  = scl & ~scl_d_r;
  assign scl_fall  = ~scl & scl_d_r;
  assign bus_start = scl & scl_d_r & sda_d_r & ~sda;
  assign bus_stop  = scl & scl_d_r & ~sda_d_r & sda;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] enable_r, enable_nxt, mode_r, mode_nxt, disch_r, disch_nxt;
  logic [7:0] low_r, low_nxt, high_r, high_nxt, slew_r, slew_nxt;
  logic       wr_en;
  logic [7:0] wr_addr, wr_data;
  logic       ramp_flag;

  always_comb begin
    enable_nxt = enable_r;
    mode_nxt   = mode_r;
    disch_nxt  = disch_r;
    low_nxt    = low_r;
    high_nxt   = high_r;
    slew_nxt   = slew_r;
    if (wr_en) begin
      // Read-only bits are masked off on every write
      if (wr_addr == step_down_ctrl_pkg::ADDR_ENABLE) begin
        enable_nxt = wr_data & step_down_ctrl_pkg::MASK_ENABLE;
      end else if (wr_addr == step_down_ctrl_pkg::ADDR_MODE) begin
        mode_nxt = wr_data & step_down_ctrl_pkg::MASK_MODE;
      end else if (wr_addr == step_down_ctrl_pkg::ADDR_DISCHARGE) begin
        disch_nxt = wr_data & step_down_ctrl_pkg::MASK_DISCHARGE;
      end else if (wr_addr == step_down_ctrl_pkg::ADDR_B_LOW) begin
        low_nxt = wr_data & step_down_ctrl_pkg::MASK_CODE;
      end else if (wr_addr == step_down_ctrl_pkg::ADDR_B_HIGH) begin
        high_nxt = wr_data & step_down_ctrl_pkg::MASK_CODE;
      end else if (wr_addr == step_down_ctrl_pkg::ADDR_SLEW) begin
        slew_nxt = wr_data & step_down_ctrl_pkg::MASK_SLEW;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      enable_r <= step_down_ctrl_pkg::RST_ENABLE;
      mode_r   <= step_down_ctrl_pkg::RST_MODE;
      disch_r  <= step_down_ctrl_pkg::RST_DISCHARGE;
      low_r    <= step_down_ctrl_pkg::RST_B_LOW;
      high_r   <= step_down_ctrl_pkg::RST_B_HIGH;
      slew_r   <= step_down_ctrl_pkg::RST_SLEW;
    end else begin
      enable_r <= enable_nxt;
      mode_r   <= mode_nxt;
      disch_r  <= disch_nxt;
      low_r    <= low_nxt;
      high_r   <= high_nxt;
      slew_r   <= slew_nxt;
    end
  end

  function automatic logic [7:0] read_reg(input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    if (addr == step_down_ctrl_pkg::ADDR_STATUS) begin
      v[step_down_ctrl_pkg::POS_RAMP_MIRROR] = ramp_flag;
    end else if (addr == step_down_ctrl_pkg::ADDR_ENABLE) begin
      v = enable_r;
    end else if (addr == step_down_ctrl_pkg::ADDR_MODE) begin
      v = mode_r;
    end else if (addr == step_down_ctrl_pkg::ADDR_DISCHARGE) begin
      v = disch_r;
      v[step_down_ctrl_pkg::POS_RAMP_FLAG] = ramp_flag;
    end else if (addr == step_down_ctrl_pkg::ADDR_B_LOW) begin
      v = low_r;
    end else if (addr == step_down_ctrl_pkg::ADDR_B_HIGH) begin
      v = high_r;
    end else if (addr == step_down_ctrl_pkg::ADDR_SLEW) begin
      v = slew_r;
    end
    return v;
  endfunction

  // ****************************************************************
  // Serial bus slave
  // ****************************************************************
  step_down_ctrl_pkg::bus_state_e bus_st_r, bus_st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shreg_r, shreg_nxt, ptr_r, ptr_nxt;
  logic       rw_r, rw_nxt, oe_r, oe_nxt;

  always_comb begin
    bus_st_nxt = bus_st_r;
    cnt_nxt    = cnt_r;
    shreg_nxt  = shreg_r;
    ptr_nxt    = ptr_r;
    rw_nxt     = rw_r;
    oe_nxt     = oe_r;
    wr_en      = 1'b0;
    wr_addr    = ptr_r;
    wr_data    = shreg_r;
    if (bus_start) begin
      bus_st_nxt = step_down_ctrl_pkg::BUS_ADDR;
      cnt_nxt    = 4'h0;
      oe_nxt     = 1'b0;
    end else if (bus_stop) begin
      bus_st_nxt = step_down_ctrl_pkg::BUS_IDLE;
      oe_nxt     = 1'b0;
    end else if (scl_rise) begin
      if (bus_st_r == step_down_ctrl_pkg::BUS_ADDR || bus_st_r == step_down_ctrl_pkg::BUS_REG ||
          bus_st_r == step_down_ctrl_pkg::BUS_WDATA) begin
        shreg_nxt = {shreg_r[6:0], sda};
        cnt_nxt   = cnt_r + 4'h1;
      end else if (bus_st_r == step_down_ctrl_pkg::BUS_RDATA) begin
        cnt_nxt = cnt_r + 4'h1;
      end else if (bus_st_r == step_down_ctrl_pkg::BUS_RACK) begin
        rw_nxt = ~sda; // Master ack: keep reading
      end
    end else if (scl_fall) begin
      case (bus_st_r)
        step_down_ctrl_pkg::BUS_ADDR: begin
          if (cnt_r == step_down_ctrl_pkg::BITS_PER_BYTE) begin
            if (shreg_r[7:1] == SLAVE_ADDR) begin
              rw_nxt     = shreg_r[0];
              oe_nxt     = 1'b1;
              bus_st_nxt = step_down_ctrl_pkg::BUS_ACK_ADDR;
            end else begin
              bus_st_nxt = step_down_ctrl_pkg::BUS_IDLE;
            end
          end
        end
        step_down_ctrl_pkg::BUS_ACK_ADDR: begin
          cnt_nxt = 4'h0;
          if (rw_r) begin
            shreg_nxt  = read_reg(ptr_r);
            oe_nxt     = ~shreg_nxt[7];
            bus_st_nxt = step_down_ctrl_pkg::BUS_RDATA;
          end else begin
            oe_nxt     = 1'b0;
            bus_st_nxt = step_down_ctrl_pkg::BUS_REG;
          end
        end
        step_down_ctrl_pkg::BUS_REG: begin
          if (cnt_r == step_down_ctrl_pkg::BITS_PER_BYTE) begin
            ptr_nxt    = shreg_r;
            oe_nxt     = 1'b1;
            bus_st_nxt = step_down_ctrl_pkg::BUS_ACK_REG;
          end
        end
        step_down_ctrl_pkg::BUS_ACK_REG, step_down_ctrl_pkg::BUS_ACK_WDATA: begin
          oe_nxt     = 1'b0;
          cnt_nxt    = 4'h0;
          bus_st_nxt = step_down_ctrl_pkg::BUS_WDATA;
        end
        step_down_ctrl_pkg::BUS_WDATA: begin
          if (cnt_r == step_down_ctrl_pkg::BITS_PER_BYTE) begin
            wr_en      = 1'b1;
            ptr_nxt    = ptr_r + 8'h01;
            oe_nxt     = 1'b1;
            bus_st_nxt = step_down_ctrl_pkg::BUS_ACK_WDATA;
          end
        end
        step_down_ctrl_pkg::BUS_RDATA: begin
          if (cnt_r == step_down_ctrl_pkg::BITS_PER_BYTE) begin
            oe_nxt     = 1'b0;
            ptr_nxt    = ptr_r + 8'h01;
            bus_st_nxt = step_down_ctrl_pkg::BUS_RACK;
          end else begin
            oe_nxt = ~shreg_r[3'h7 - cnt_r[2:0]];
          end
        end
        step_down_ctrl_pkg::BUS_RACK: begin
          cnt_nxt = 4'h0;
          if (rw_r) begin
            shreg_nxt  = read_reg(ptr_r);
            oe_nxt     = ~shreg_nxt[7];
            bus_st_nxt = step_down_ctrl_pkg::BUS_RDATA;
          end else begin
            bus_st_nxt = step_down_ctrl_pkg::BUS_IDLE;
          end
        end
        default: bus_st_nxt = step_down_ctrl_pkg::BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      bus_st_r <= step_down_ctrl_pkg::BUS_IDLE;
      cnt_r    <= 4'h0;
      shreg_r  <= 8'h00;
      ptr_r    <= 8'h00;
      rw_r     <= 1'b0;
      oe_r     <= 1'b0;
    end else begin
      bus_st_r <= bus_st_nxt;
      cnt_r    <= cnt_nxt;
      shreg_r  <= shreg_nxt;
      ptr_r    <= ptr_nxt;
      rw_r     <= rw_nxt;
      oe_r     <= oe_nxt;
    end
  end

  // ****************************************************************
  // Converter B voltage ramp
  // ****************************************************************
  step_down_ctrl_pkg::ramp_state_e ramp_st_r, ramp_st_nxt;
  logic [5:0]  code_r, code_nxt, target;
  logic [15:0] tick_r, tick_nxt;

  // Cycles for one code step; step size depends on the code region
  function automatic logic [15:0] step_cycles(input logic [2:0] slew, input logic [5:0] lo);
    int step_uv;
    int rate;
    int cyc;
    step_uv = step_down_ctrl_pkg::STEP_TOP_UV;
    if (lo < step_down_ctrl_pkg::CODE_FINE_TOP + 6'h01) begin
      step_uv = step_down_ctrl_pkg::STEP_FINE_UV;
    end else if (lo < step_down_ctrl_pkg::CODE_COARSE_TOP + 6'h01) begin
      step_uv = step_down_ctrl_pkg::STEP_COARSE_UV;
    end
    rate = step_down_ctrl_pkg::SLEW_RATE_UV_PER_US[slew];
    cyc = step_uv * step_down_ctrl_pkg::NS_PER_US / rate / CLK_PERIOD_NS;
    if (cyc < 1) begin
      cyc = 1;
    end
    return cyc[15:0];
  endfunction

  assign target    = sel_sync_r[1] ? high_r[5:0] : low_r[5:0];
  assign ramp_flag = (code_r != target);

  always_comb begin
    ramp_st_nxt = ramp_st_r;
    code_nxt    = code_r;
    tick_nxt    = tick_r;
    case (ramp_st_r)
      step_down_ctrl_pkg::RAMP_IDLE: begin
        // Any mismatch, from a write or a pin change, starts a ramp
        if (code_r != target) begin
          ramp_st_nxt = step_down_ctrl_pkg::RAMP_MOVING;
          tick_nxt    = 16'h0000;
        end
      end
      step_down_ctrl_pkg::RAMP_MOVING: begin
        if (code_r == target) begin
          ramp_st_nxt = step_down_ctrl_pkg::RAMP_IDLE;
        end else if (slew_r[2:0] == step_down_ctrl_pkg::SLEW_IMMEDIATE) begin
          code_nxt = target;
        end else if (tick_r + 16'h0001 >= step_cycles(slew_r[2:0],
                     (target > code_r) ? code_r : code_r - 6'h01)) begin
          tick_nxt = 16'h0000;
          code_nxt = (target > code_r) ? code_r + 6'h01 : code_r - 6'h01;
        end else begin
          tick_nxt = tick_r + 16'h0001;
        end
      end
      default: ramp_st_nxt = step_down_ctrl_pkg::RAMP_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ramp_st_r <= step_down_ctrl_pkg::RAMP_IDLE;
      code_r    <= step_down_ctrl_pkg::RST_B_LOW[5:0];
      tick_r    <= 16'h0000;
    end else begin
      ramp_st_r <= ramp_st_nxt;
      code_r    <= code_nxt;
      tick_r    <= tick_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign sda_o                  = 1'b0;
  assign sda_oe_o               = oe_r;
  assign power_down_output_o    = 1'b0;
  assign power_down_output_oe_o = ~enable_r[step_down_ctrl_pkg::POS_POWER_DOWN];
  assign ripple_opt_a_o         = mode_r[step_down_ctrl_pkg::POS_RIPPLE_A];
  assign ripple_opt_b_o         = mode_r[step_down_ctrl_pkg::POS_RIPPLE_B];
  assign forced_pwm_a_o         = mode_r[step_down_ctrl_pkg::POS_FPWM_A];
  assign forced_pwm_b_o         = mode_r[step_down_ctrl_pkg::POS_FPWM_B];
  assign discharge_en_o         = disch_r[5:0];
  assign converter_b_code_o     = code_r;
  assign converter_b_ramp_o     = ramp_flag;

endmodule

// file: verif/step_down_ctrl_asserts.sv
// Port-level assertion checker for the step-down control block
`timescale 1ns/1ns
module step_down_ctrl_checker #(
  parameter int CLK_PERIOD_NS = 100
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  // Watched outputs
  input  wire logic       sda_o,
  input  wire logic       sda_oe_o,
  input  wire logic       power_down_output_o,
  input  wire logic       power_down_output_oe_o,
  input  wire logic       ripple_opt_a_o,
  input  wire logic       ripple_opt_b_o,
  input  wire logic       forced_pwm_a_o,
  input  wire logic       forced_pwm_b_o,
  input  wire logic [5:0] discharge_en_o,
  input  wire logic [5:0] converter_b_code_o,
  input  wire logic       converter_b_ramp_o
);
  // Retargeting may restart the step timer, hence twice the slowest step
  localparam int STALL_MAX = 2 * (100000 * 1000 / 110 / CLK_PERIOD_NS) + 8;
  logic [15:0] stall_r;
  logic [15:0] stall_nxt;
  logic [5:0]  code_prev_r;

  always_comb begin
    stall_nxt = 16'h0000;
    if (converter_b_ramp_o && (converter_b_code_o == code_prev_r)) begin
      stall_nxt = stall_r + 16'h0001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      stall_r     <= 16'h0000;
      code_prev_r <= 6'h10;
    end else begin
      stall_r     <= stall_nxt;
      code_prev_r <= converter_b_code_o;
    end
  end

  // ******
  // Properties
  // ******
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sequence s_released;
    $rose(resetn_i);
  endsequence
  sequence s_code_moved;
    $changed(converter_b_code_o);
  endsequence
  sequence s_reg_update;
    $changed({power_down_output_oe_o, ripple_opt_a_o, ripple_opt_b_o,
              forced_pwm_a_o, forced_pwm_b_o, discharge_en_o});
  endsequence

  a_pd_open_drain: assert property (power_down_output_o == 1'b0)
    else $error("power-down pin driven high");
  a_sda_open_drain: assert property (sda_o == 1'b0)
    else $error("serial data pin driven high");
  a_pd_reset_pull: assert property (s_released |-> power_down_output_oe_o)
    else $error("power-down pin not pulled low after reset");
  a_mode_reset_clear: assert property (s_released |-> !(ripple_opt_a_o ||
    ripple_opt_b_o || forced_pwm_a_o || forced_pwm_b_o))
    else $error("mode outputs not cleared by reset");
  a_discharge_reset: assert property (s_released |-> discharge_en_o == 6'h0F)
    else $error("discharge enables wrong after reset");
  a_code_reset_low: assert property (s_released |-> converter_b_code_o == 6'h10)
    else $error("voltage code wrong after reset");
  a_code_needs_ramp: assert property (s_code_moved |-> $past(converter_b_ramp_o))
    else $error("voltage code moved without ramp flag");
  a_ramp_keeps_moving: assert property (stall_r <= STALL_MAX)
    else $error("ramp flag high but code not stepping");
  a_write_in_ack: assert property (s_reg_update |-> sda_oe_o || $past(sda_oe_o))
    else $error("control output changed outside a write");
endmodule

bind step_down_mode_and_voltage_ctrl step_down_ctrl_checker #(
  .CLK_PERIOD_NS(CLK_PERIOD_NS)
) i_checker (
  .clock_i               (clock_i),
  .resetn_i              (resetn_i),
  .sda_o                 (sda_o),
  .sda_oe_o              (sda_oe_o),
  .power_down_output_o   (power_down_output_o),
  .power_down_output_oe_o(power_down_output_oe_o),
  .ripple_opt_a_o        (ripple_opt_a_o),
  .ripple_opt_b_o        (ripple_opt_b_o),
  .forced_pwm_a_o        (forced_pwm_a_o),
  .forced_pwm_b_o        (forced_pwm_b_o),
  .discharge_en_o        (discharge_en_o),
  .converter_b_code_o    (converter_b_code_o),
  .converter_b_ramp_o    (converter_b_ramp_o)
);

// file: verif/i2c_host_model.sv
// Serial bus host model issuing register writes and reads
`timescale 1ns/1ns
module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h48
) (
  // Clock
  input  wire logic       clock_i,
  // Bus wires
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            sda_low_o,
  // Read result
  output logic            rd_valid_o,
  output logic [7:0]      rd_data_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    rd_valid_o = 1'b0;
    rd_data_o = 8'h00;
  end

  task automatic half();
    repeat (6) @(posedge clock_i);
  endtask

  // Data moves only mid low phase, so no false start or stop is seen
  task automatic bit_cycle(input logic low, output logic seen);
    sda_low_o <= low;
    half();
    scl_o <= 1'b1;
    half();
    seen = sda_i;
    scl_o <= 1'b0;
    half();
  endtask

  task automatic start();
    sda_low_o <= 1'b0;
    half();
    scl_o <= 1'b1;
    half();
    sda_low_o <= 1'b1;
    half();
    scl_o <= 1'b0;
    half();
  endtask

  task automatic stop();
    sda_low_o <= 1'b1;
    half();
    scl_o <= 1'b1;
    half();
    sda_low_o <= 1'b0;
    half();
  endtask

  task automatic send(input logic [7:0] b);
    logic seen;
    for (int i = 7; i >= 0; i--) bit_cycle(!b[i], seen);
    bit_cycle(1'b0, seen);
  endtask

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    start();
    send({DEV_ADDR, 1'b0});
    send(addr);
    send(data);
    stop();
  endtask

  task automatic read_reg(input logic [7:0] addr);
    logic [7:0] b;
    logic       seen;
    start();
    send({DEV_ADDR, 1'b0});
    send(addr);
    start();
    send({DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) bit_cycle(1'b0, b[i]);
    bit_cycle(1'b0, seen);
    stop();
    rd_data_o <= b;
    rd_valid_o <= 1'b1;
    @(posedge clock_i);
    rd_valid_o <= 1'b0;
  endtask
endmodule

// file: verif/testbench.sv
// Self-checking bench for the step-down mode and voltage control block
`timescale 1ns/1ns
module testbench;
  typedef struct {
    string      name;
    logic [7:0] exp;
  } note_s;
  localparam int CLK_NS = 5000;
  localparam int STEP_CYC = 25000 * 1000 / 110 / CLK_NS;
  localparam logic [7:0] REG_A [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
                                       8'h05, 8'h06, 8'h07, 8'h20};
  localparam logic [7:0] REG_D [8] = '{8'h00, 8'h00, 8'h00, 8'h0F,
                                       8'h10, 8'h08, 8'h06, 8'h00};
  logic       clock_i;
  logic       resetn_i;
  logic       pin;
  logic       probe_v;
  logic [7:0] probe_d;
  logic [7:0] seed;
  logic [7:0] disc;
  wire        scl;
  wire        host_low;
  wire        sda_oe;
  wire        sda;
  wire        rd_valid;
  wire  [7:0] rd_data;
  wire        pd_oe;
  wire  [3:0] mode_pins;
  wire  [5:0] disc_pins;
  wire  [5:0] code;
  wire        ramp;
  int         n;
  int         fail_count;
  int         checks;
  note_s      notes[$];

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // Open-drain wire with pull-up
  assign sda = !(sda_oe | host_low);

  step_down_mode_and_voltage_ctrl #(
    .CLK_PERIOD_NS(CLK_NS)
  ) i_step_down_mode_and_voltage_ctrl (
    .clock_i               (clock_i),
    .resetn_i              (resetn_i),
    .scl_i                 (scl),
    .sda_i                 (sda),
    .sda_o                 (),
    .sda_oe_o              (sda_oe),
    .target_select_pin_i   (pin),
    .power_down_output_o   (),
    .power_down_output_oe_o(pd_oe),
    .ripple_opt_a_o        (mode_pins[3]),
    .ripple_opt_b_o        (mode_pins[2]),
    .forced_pwm_a_o        (mode_pins[1]),
    .forced_pwm_b_o        (mode_pins[0]),
    .discharge_en_o        (disc_pins),
    .converter_b_code_o    (code),
    .converter_b_ramp_o    (ramp)
  );

  i2c_host_model i_i2c_host_model (
    .clock_i   (clock_i),
    .sda_i     (sda),
    .scl_o     (scl),
    .sda_low_o (host_low),
    .rd_valid_o(rd_valid),
    .rd_data_o (rd_data)
  );

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      fail_count++;
    end
  endtask

  task automatic take(logic [7:0] seen);
    note_s e;
    if (notes.size() == 0) begin
      check("result", seen, 8'hXX);
    end else begin
      e = notes.pop_front();
      check(e.name, seen, e.exp);
    end
  endtask

  always @(posedge clock_i) begin
    if (rd_valid === 1'b1) take(rd_data);
    if (probe_v === 1'b1) take(probe_d);
  end

  task automatic rd(logic [7:0] addr, logic [7:0] exp, string name);
    notes.push_back('{name, exp});
    i_i2c_host_model.read_reg(addr);
  endtask

  task automatic wr(logic [7:0] addr, logic [7:0] data);
    i_i2c_host_model.write_reg(addr, data);
  endtask

  task automatic probe(string name, logic [7:0] exp, logic [7:0] val);
    notes.push_back('{name, exp});
    probe_d <= val;
    probe_v <= 1'b1;
    @(posedge clock_i);
    probe_v <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic wait_ramp();
    for (n = 0; ramp === 1'b1 && n < 6000; n++) @(posedge clock_i);
    check("ramp end", {7'h00, ramp}, 8'h00);
    if (n == 6000) report_and_stop();
  endtask

  task automatic step_time();
    logic [5:0] c;
    c = code;
    for (n = 0; code === c && n < 400; n++) @(posedge clock_i);
    if (n == 400) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  task automatic defaults();
    for (int i = 0; i < 8; i++) rd(REG_A[i], REG_D[i], "reg default");
    probe("code", 8'h10, {2'h0, code});
    probe("pd drive", 8'h01, {7'h00, pd_oe});
    probe("discharge pins", 8'h0F, {2'h0, disc_pins});
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    resetn_i = 1'b0;
    pin = 1'b0;
    probe_v = 1'b0;
    probe_d = 8'h00;
    fail_count = 0;
    checks = 0;
    seed = 8'h5B;
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    wr(8'h01, 8'hFF);
    wr(8'h20, 8'hFF);
    defaults();
    for (int i = 0; i < 4; i++) begin
      wr(8'h03, 8'hF0 | (8'h01 << i));
      rd(8'h03, 8'h01 << i, "mode reg");
      probe("mode pins", 8'h01 << i, {4'h0, mode_pins});
    end
    repeat (4) begin
      seed = lfsr(seed);
      disc = seed & 8'h3F;
      wr(8'h04, seed);
      rd(8'h04, disc, "discharge reg");
      probe("discharge pins", disc, {2'h0, disc_pins});
    end
    wr(8'h02, 8'h40);
    probe("pd drive", 8'h00, {7'h00, pd_oe});
    wr(8'h02, 8'hBF);
    probe("pd drive", 8'h01, {7'h00, pd_oe});
    // Slowest slew so the flag is still up during the reads
    wr(8'h07, 8'h00);
    wr(8'h05, 8'hFF);
    step_time();
    step_time();
    probe("step cycles", 8'h01, {7'h00, n >= STEP_CYC - 1 && n <= STEP_CYC + 1});
    rd(8'h04, disc | 8'h80, "ramp flag");
    rd(8'h01, 8'h40, "ramp mirror");
    rd(8'h05, 8'h3F, "low target");
    // Code is now above 1Fh, so each step is twice as large and twice as long
    step_time();
    step_time();
    probe("coarse step", 8'h01, {7'h00, n >= 2 * STEP_CYC - 1 && n <= 2 * STEP_CYC + 1});
    wait_ramp();
    probe("code", 8'h3F, {2'h0, code});
    rd(8'h04, disc, "ramp flag");
    wr(8'h07, 8'h07);
    wr(8'h05, 8'h00);
    probe("code", 8'h00, {2'h0, code});
    wr(8'h07, 8'h06);
    wr(8'h06, 8'h25);
    pin <= 1'b1;
    repeat (4) @(posedge clock_i);
    probe("ramp", 8'h01, {7'h00, ramp});
    wait_ramp();
    probe("code", 8'h25, {2'h0, code});
    wr(8'h05, 8'h3A);
    probe("code", 8'h25, {2'h0, code});
    pin <= 1'b0;
    repeat (4) @(posedge clock_i);
    wait_ramp();
    probe("code", 8'h3A, {2'h0, code});
    resetn_i <= 1'b0;
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    defaults();
    repeat (4) @(posedge clock_i);
    if (notes.size() != 0) fail_count++;
    report_and_stop();
  end
endmodule
